// File: rtl/cbosc_pkg.sv
// constants and carrier types for the clock buffer slew/enable control block
package cbosc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_EN_BANK_LOW  = 8'h01; // enables, outputs 0-5
    localparam logic [7:0] ADDR_EN_BANK_HIGH = 8'h02; // enables, outputs 6-7
    localparam logic [7:0] ADDR_OE_READBACK  = 8'h03; // enable pin levels
    localparam logic [7:0] ADDR_OUT_SETUP    = 8'h08; // termination select
    localparam logic [7:0] ADDR_SLEW_TRIM    = 8'h4c; // output_slew_trim

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_EN_BANK_LOW   = 8'hff;
    localparam logic [7:0] RST_EN_BANK_HIGH  = 8'h0f;
    localparam logic [7:0] RST_OUT_SETUP     = 8'h00;
    localparam logic [7:0] RST_SLEW_TRIM     = 8'h66;
    localparam logic [7:0] RD_UNMAPPED       = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LOW_BANK_FIRST_BIT  = 1; // output 0 at bit 1, up to 5
    localparam int LOW_BANK_OUTPUTS    = 6;
    localparam int HIGH_BANK_OUT6_BIT  = 0;
    localparam int HIGH_BANK_OUT7_BIT  = 2;
    localparam int TERM_SEL_BIT        = 5;
    localparam int SETUP_RW_BITS       = 6; // bits 7-6 read as zero
    localparam int LOWER_CODE_LSB      = 0;
    localparam int UPPER_CODE_LSB      = 4;
    localparam int CODE_W              = 4;
    localparam int GROUP_SIZE          = 4;
    localparam int NUM_OUTPUTS         = 8;

    // ------------------------------------------------------------------
    // strap decode and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] STRAP_LOW  = 2'h0;
    localparam logic [1:0] STRAP_MID  = 2'h1;
    localparam logic [1:0] STRAP_HIGH = 2'h2;
    localparam int         SYNC_STAGES = 2;
    localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2; // after sync settles

    // ------------------------------------------------------------------
    // register access request from the bus engine
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;   // one-cycle write strobe
        logic       rdEn;   // one-cycle read strobe
        logic [7:0] addr;   // register address
        logic [7:0] wrData; // write byte
    } cbosc_reg_req_t;

    // per-output state handed to the drivers
    typedef struct packed {
        logic [NUM_OUTPUTS-1:0]        enable;  // output running
        logic [NUM_OUTPUTS*CODE_W-1:0] slew;    // trim code per output
        logic                          term100; // 1 = 100 ohm, 0 = 85 ohm
    } cbosc_drv_cfg_t;

endpackage

// File: rtl/cbosc_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module cbosc_sync
    import cbosc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // pin side
    input  wire logic [WIDTH-1:0] pinIn,
    // clock-domain side
    output logic      [WIDTH-1:0] syncOut
);

    // ------------------------------------------------------------------
    // two stages; the first is read only by the second
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q; // first stage, may go metastable

    // sample the pin, then retime
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= pinIn;
            syncOut <= meta_q;
        end
    end

endmodule

// File: rtl/cbosc_ctrl.sv
// control registers, output enables and slew trim for the fanout buffer
//
// Function
// - two trim groups: outputs 0-3, 4-7
// - upper trim field bits 7-4, reset 6
// - lower trim field bits 3-0, reset 6
// - outputs run only when software bit and pin both enable
// - software enables reset to one
// - floating active-low enable pin reads low
// - target address picked from strap levels
// - termination defaults to 85 ohm
// - reference clock fanned out unchanged
// - slew trim at address 4Ch, reset 66h
// - software enable: 0 off, 1 on
// - termination bit: 0 85 ohm, 1 100 ohm
`timescale 1ns/1ps
module cbosc_ctrl
    import cbosc_pkg::*;
#(
    parameter logic [6:0] ADDR_BASE = 7'h68 // first strap address, plain
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    // register port from the bus engine
    input  wire cbosc_reg_req_t         regReq,
    output logic      [7:0]             regRdData,
    output logic                        regRdValid,
    // board pins
    input  wire logic [NUM_OUTPUTS-1:0] oeN,
    input  wire logic [1:0]             addrStrapA,
    input  wire logic [1:0]             addrStrapB,
    // reference clock and outputs
    input  wire logic                   refClk,
    output logic      [NUM_OUTPUTS-1:0] clockOutputPair,
    // driver configuration and bus address
    output cbosc_drv_cfg_t              drvCfg,
    output logic      [6:0]             targetAddr,
    output logic                        targetAddrValid
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]             enBankLow_q;   // enable_bank_low
    logic [7:0]             enBankHigh_q;  // enable_bank_high
    logic [SETUP_RW_BITS-1:0] outSetup_q;  // termination_select and spares
    logic [7:0]             slewTrim_q;    // output_slew_trim
    logic [NUM_OUTPUTS-1:0] swEnable;      // software bit per output
    logic [NUM_OUTPUTS-1:0] oeNSync;       // synchronised pin levels
    logic [NUM_OUTPUTS-1:0] outEnable_q;   // registered output enable
    logic [3:0]             strapSync;     // synchronised straps
    logic [1:0]             strapCnt_q;    // settle counter after reset
    logic [7:0]             rdData_d;      // read mux
    logic [3:0]             strapIndex;    // 0..8

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // the pins are asynchronous; an unconnected pin has its pulldown and
    // therefore shows up here as low, i.e. asserted
    cbosc_sync #(.WIDTH(NUM_OUTPUTS)) u_oe_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pinIn   (oeN),
        .syncOut (oeNSync)
    );

    cbosc_sync #(.WIDTH(4)) u_strap_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pinIn   ({addrStrapA, addrStrapB}),
        .syncOut (strapSync)
    );

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // enable banks; reserved bits store but steer nothing
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            enBankLow_q  <= RST_EN_BANK_LOW;
            enBankHigh_q <= RST_EN_BANK_HIGH;
        end else if (regReq.wrEn) begin
            if (regReq.addr == ADDR_EN_BANK_LOW) begin
                enBankLow_q <= regReq.wrData;
            end
            if (regReq.addr == ADDR_EN_BANK_HIGH) begin
                enBankHigh_q <= regReq.wrData;
            end
        end
    end

    // output setup; top two bits are read-only zero and not stored
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            outSetup_q <= RST_OUT_SETUP[SETUP_RW_BITS-1:0];
        end else if (regReq.wrEn && regReq.addr == ADDR_OUT_SETUP) begin
            outSetup_q <= regReq.wrData[SETUP_RW_BITS-1:0];
        end
    end

    // slew trim; a whole-byte write, so software rewrites both codes and
    // an unchanged code keeps its drivers steady
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slewTrim_q <= RST_SLEW_TRIM;
        end else if (regReq.wrEn && regReq.addr == ADDR_SLEW_TRIM) begin
            slewTrim_q <= regReq.wrData;
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    // unmapped addresses read zero
    always_comb begin
        rdData_d = RD_UNMAPPED;
        unique case (regReq.addr)
            ADDR_EN_BANK_LOW:  rdData_d = enBankLow_q;
            ADDR_EN_BANK_HIGH: rdData_d = enBankHigh_q;
            ADDR_OE_READBACK:  rdData_d = oeNSync;
            ADDR_OUT_SETUP:    rdData_d = {2'h0, outSetup_q};
            ADDR_SLEW_TRIM:    rdData_d = slewTrim_q;
            default:           rdData_d = RD_UNMAPPED;
        endcase
    end

    // answer one cycle after the strobe, data held until the next read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regReq.rdEn;
            if (regReq.rdEn) begin
                regRdData <= rdData_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // output enable combination
    // ------------------------------------------------------------------
    // map the scattered software bits onto output numbers
    generate
        for (genvar i = 0; i < LOW_BANK_OUTPUTS; i++) begin : g_low_en
            assign swEnable[i] = enBankLow_q[LOW_BANK_FIRST_BIT + i];
        end
    endgenerate
    assign swEnable[6] = enBankHigh_q[HIGH_BANK_OUT6_BIT];
    assign swEnable[7] = enBankHigh_q[HIGH_BANK_OUT7_BIT];

    // both controls must agree; registering keeps the gate glitch free
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            outEnable_q <= '0;
        end else begin
            outEnable_q <= swEnable & ~oeNSync;
        end
    end

    // pass-through fanout; the analog path adds no divider, so the
    // frequency is that of the reference
    assign clockOutputPair = {NUM_OUTPUTS{refClk}} & outEnable_q;

    // ------------------------------------------------------------------
    // driver configuration
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_slew
            // outputs below GROUP_SIZE take the lower code
            if (i < GROUP_SIZE) begin : g_lower
                assign drvCfg.slew[i*CODE_W +: CODE_W] =
                    slewTrim_q[LOWER_CODE_LSB +: CODE_W];
            end else begin : g_upper
                assign drvCfg.slew[i*CODE_W +: CODE_W] =
                    slewTrim_q[UPPER_CODE_LSB +: CODE_W];
            end
        end
    endgenerate
    assign drvCfg.enable  = outEnable_q;
    assign drvCfg.term100 = outSetup_q[TERM_SEL_BIT];

    // ------------------------------------------------------------------
    // strap address capture
    // ------------------------------------------------------------------
    // three-level straps: low, mid (open), high; code 3 treated as mid
    function automatic logic [3:0] strapLevel(input logic [1:0] s);
        logic [3:0] v;
        v = 4'h1;
        if (s == STRAP_LOW) v = 4'h0;
        if (s == STRAP_HIGH) v = 4'h2;
        return v;
    endfunction

    assign strapIndex = 4'((strapLevel(strapSync[3:2]) * 4'h3) +
                           strapLevel(strapSync[1:0]));

    // caught once after release, once the synchroniser has settled;
    // later strap movement is ignored so the address cannot jump
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strapCnt_q      <= 2'h0;
            targetAddr      <= 7'h00;
            targetAddrValid <= 1'b0;
        end else if (!targetAddrValid) begin
            strapCnt_q <= strapCnt_q + 2'h1;
            if (strapCnt_q == STRAP_CAPTURE_CNT) begin
                targetAddr      <= ADDR_BASE + 7'(strapIndex);
                targetAddrValid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // the first edge after release still shows the reset value of the
    // gate register, so only edges that follow a running edge are checked
    a_enable_both_ctrl: assert property (
        $past(arst_n) |-> outEnable_q == $past(swEnable & ~oeNSync))
        else $error("output enable does not follow both controls");

    // pin path is two sync flops plus the gate register, so a pin held
    // high for four samples must have stopped its output
    a_pin_to_output: assert property (
        (swEnable[3] && $stable(swEnable[3]) && oeN[3]) [*4]
        |-> !outEnable_q[3])
        else $error("deasserted pin left output running");

    a_sw_bit_off: assert property (
        !swEnable[7] |=> !outEnable_q[7])
        else $error("cleared software bit left output on");

    a_trim_write_lands: assert property (
        regReq.wrEn && regReq.addr == ADDR_SLEW_TRIM
        |=> slewTrim_q == $past(regReq.wrData))
        else $error("trim write not stored");

    a_lower_group_code: assert property (
        drvCfg.slew[3*CODE_W +: CODE_W] == slewTrim_q[3:0] &&
        drvCfg.slew[0 +: CODE_W] == slewTrim_q[3:0])
        else $error("lower group code wrong");

    a_upper_group_code: assert property (
        drvCfg.slew[4*CODE_W +: CODE_W] == slewTrim_q[7:4] &&
        drvCfg.slew[7*CODE_W +: CODE_W] == slewTrim_q[7:4])
        else $error("upper group code wrong");

    a_other_write_keeps: assert property (
        !(regReq.wrEn && regReq.addr == ADDR_SLEW_TRIM)
        |=> $stable(slewTrim_q))
        else $error("trim changed without a trim write");

    a_term_select: assert property (
        regReq.wrEn && regReq.addr == ADDR_OUT_SETUP
        |=> drvCfg.term100 == $past(regReq.wrData[TERM_SEL_BIT]))
        else $error("termination select not applied");

    a_read_answer: assert property (
        regReq.rdEn && regReq.addr == ADDR_SLEW_TRIM && !regReq.wrEn
        |=> regRdValid && regRdData == $past(slewTrim_q))
        else $error("trim readback wrong");

    a_addr_capture: assert property (
        $rose(targetAddrValid) |-> ##1 $stable(targetAddr) [*4])
        else $error("target address moved after capture");

    c_trim_write: cover property (
        regReq.wrEn && regReq.addr == ADDR_SLEW_TRIM);
    c_pin_disable: cover property (swEnable[2] ##1 oeNSync[2]);
    c_term_100: cover property ($rose(drvCfg.term100));
    c_addr_valid: cover property ($rose(targetAddrValid));

endmodule

// File: verif/cbosc_board_model.sv
// board-side model: enable pins with pulldowns, strap pins, reference clock
`timescale 1ns/1ps
module cbosc_board_model #(
    parameter logic [1:0] STRAP_A  = 2'h2, // high strap level
    parameter logic [1:0] STRAP_B  = 2'h1, // mid strap level
    parameter realtime    REF_HALF = 5.0   // 100 MHz reference
) (
    // levels requested by the bench
    input  wire logic [7:0] pinDrive,
    input  wire logic [7:0] pinFloat,
    // board pins
    output logic      [7:0] oeN,
    output logic      [1:0] addrStrapA,
    output logic      [1:0] addrStrapB,
    output logic            refClk
);
    // -----------------------------------------------------------------
    // pin levels
    // -----------------------------------------------------------------
    // a floating pin is pulled to ground, so it reads as asserted
    assign oeN        = pinDrive & ~pinFloat;
    // straps are fixed resistors, the bench picks a unique address
    assign addrStrapA = STRAP_A;
    assign addrStrapB = STRAP_B;

    // free-running reference, offset so it never lines up with clk_sys
    initial begin
        refClk = 1'b0;
        #1.3;
        forever #REF_HALF refClk = ~refClk;
    end
endmodule

// File: verif/test_clock_buffer_output_slew_control.sv
// self-checking bench for the slew trim and output enable control block
`timescale 1ns/1ps
module test_clock_buffer_output_slew_control import cbosc_pkg::*;;
    localparam logic [6:0] BASE = 7'h68; // first strap address
    logic           clkSys, arstN;     // clock and reset
    cbosc_reg_req_t regReq;            // register request
    logic [7:0]     regRdData, oeN;    // read byte, enable pins
    logic           regRdValid, refClk, addrValid;
    logic [1:0]     strapA, strapB;    // strap levels
    logic [7:0]     clkOut, pinDrive, pinFloat, swLow, swHigh;
    cbosc_drv_cfg_t drvCfg;            // driver settings
    logic [6:0]     targetAddr;        // bus address
    int             errCount, testsRun, cycles;
    logic [7:0]     codes [3] = '{8'ha5, 8'h0f, 8'hf0};

    cbosc_ctrl #(.ADDR_BASE(BASE)) DUT (.clk_sys(clkSys), .arst_n(arstN),
        .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
        .oeN(oeN), .addrStrapA(strapA), .addrStrapB(strapB),
        .refClk(refClk), .clockOutputPair(clkOut), .drvCfg(drvCfg),
        .targetAddr(targetAddr), .targetAddrValid(addrValid));
    cbosc_board_model BOARD (.pinDrive(pinDrive), .pinFloat(pinFloat),
        .oeN(oeN), .addrStrapA(strapA), .addrStrapB(strapB),
        .refClk(refClk));

    // -----------------------------------------------------------------
    // clock and hang guard
    // -----------------------------------------------------------------
    initial begin
        clkSys = 1'b0;
        forever #2.5 clkSys = ~clkSys;
    end
    // whole run needs about 140 cycles, so 5000 means a hang
    always @(posedge clkSys) begin
        cycles++;
        if (cycles > 5000) begin
            errCount++;
            $display("unexpected at %0t: run did not finish", $time);
            results();
        end
    end

    // -----------------------------------------------------------------
    // compare and bus tasks
    // -----------------------------------------------------------------
    task automatic chk_reg(input logic [7:0] got, exp, input string what);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t: %s read %h want %h",
                     $time, what, got, exp);
        end
    endtask
    task automatic chk_out(input logic [31:0] got, exp, input string what);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t: %s is %h want %h",
                     $time, what, got, exp);
        end
    endtask
    // write strobe for one cycle, then let the value reach the outputs
    task automatic wr(input logic [7:0] a, d);
        @(posedge clkSys) regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clkSys) regReq.wrEn <= 1'b0;
        repeat (2) @(posedge clkSys);
    endtask
    // answer stands just after the taking edge
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clkSys) regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clkSys) regReq.rdEn <= 1'b0;
        #1;
        chk_out({31'h0, regRdValid}, 32'h1, "read valid");
        chk_reg(regRdData, exp, "register");
    endtask
    // expected running set: software bit and asserted pin
    function automatic logic [7:0] exp_en();
        logic [7:0] sw;
        sw = {swHigh[2], swHigh[0], swLow[6:1]};
        return sw & ~(pinDrive & ~pinFloat);
    endfunction
    task automatic en_case(input logic [7:0] lo, hi, drv, flt);
        swLow = lo;
        swHigh = hi;
        wr(ADDR_EN_BANK_LOW, lo);
        wr(ADDR_EN_BANK_HIGH, hi);
        @(posedge clkSys) pinDrive <= drv;
        pinFloat <= flt;
        repeat (4) @(posedge clkSys);
        #1;
        chk_out(drvCfg.enable, exp_en(), "enable");
        rd(ADDR_OE_READBACK, drv & ~flt);
        @(posedge refClk) #1;
        chk_out(clkOut, exp_en(), "outputs high");
        @(negedge refClk) #1;
        chk_out(clkOut, 32'h0, "outputs low");
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // -----------------------------------------------------------------
    // test sequence
    // -----------------------------------------------------------------
    initial begin
        regReq = '0;
        arstN = 1'b0;
        pinDrive = 8'h00;
        pinFloat = 8'hff;
        swLow = 8'hff;
        swHigh = 8'h0f;
        repeat (6) @(posedge clkSys);
        arstN <= 1'b1;
        repeat (4) @(posedge clkSys);
        #1;
        // defaults after reset, all enable pins left floating
        chk_out(drvCfg.slew, {8{4'h6}}, "slew");
        chk_out({31'h0, drvCfg.term100}, 32'h0, "term");
        chk_out({addrValid, targetAddr}, {1'b1, BASE + 7'h7}, "addr");
        chk_out(drvCfg.enable, 32'hff, "enable");
        rd(ADDR_SLEW_TRIM, 8'h66);
        rd(ADDR_EN_BANK_LOW, 8'hff);
        rd(ADDR_EN_BANK_HIGH, 8'h0f);
        rd(ADDR_OUT_SETUP, 8'h00);
        rd(8'h40, RD_UNMAPPED);
        $display("test reset defaults done");
        // each group follows only its own nibble
        foreach (codes[i]) begin
            wr(ADDR_SLEW_TRIM, codes[i]);
            chk_out(drvCfg.slew, {{4{codes[i][7:4]}}, {4{codes[i][3:0]}}},
                    "slew");
            rd(ADDR_SLEW_TRIM, codes[i]);
        end
        $display("test slew groups done");
        // software bits against pins, including floating pins
        en_case(8'hff, 8'h0f, 8'h08, 8'h00);
        en_case(8'hfc, 8'h0f, 8'h80, 8'h00);
        en_case(8'hff, 8'h0b, 8'h00, 8'h00);
        en_case(8'h82, 8'h0e, 8'h00, 8'hff);
        $display("test output enables done");
        // termination select, reserved bits, read-only readback
        wr(ADDR_OUT_SETUP, 8'h20);
        chk_out({31'h0, drvCfg.term100}, 32'h1, "term");
        wr(ADDR_OUT_SETUP, 8'hff);
        rd(ADDR_OUT_SETUP, 8'h3f);
        wr(ADDR_OUT_SETUP, 8'h00);
        chk_out({31'h0, drvCfg.term100}, 32'h0, "term");
        wr(ADDR_OE_READBACK, 8'h55);
        rd(ADDR_OE_READBACK, 8'h00);
        $display("test termination done");
        // reset in mid-run restores the trim default
        @(posedge clkSys) arstN <= 1'b0;
        repeat (2) @(posedge clkSys);
        arstN <= 1'b1;
        repeat (4) @(posedge clkSys);
        rd(ADDR_SLEW_TRIM, 8'h66);
        $display("test second reset done");
        results();
    end
endmodule
